// ==== bench/dmp_mem_model.sv ====
`default_nettype none

module dmp_mem_model #(
  parameter int AW = 24,
  parameter int DW = 48
) (
  input  wire logic          clk_i,
  input  wire logic [AW-1:0] addr_i,
  input  wire logic [DW-1:0] wdata_i,
  input  wire logic          rd_n_i,
  input  wire logic          wr_n_i,
  input  wire logic          float_i,
  input  wire logic [7:0]    stall_i,
  output logic               ack_o,
  output logic      [DW-1:0] rdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [DW-1:0] mem [16];
  logic [DW-1:0] last_q = '0;
  logic [7:0]    cnt_q  = '0;

  // Count never clears mid-access, so ack holds across a float release
  assign ack_o = cnt_q >= stall_i;
  always @(posedge clk_i) begin
    cnt_q <= (rd_n_i && wr_n_i) ? 8'h00 : cnt_q + 8'h01;
    if (!wr_n_i && !float_i && ack_o) mem[addr_i[3:0]] <= wdata_i;
    if (!rd_n_i && !float_i) last_q <= mem[addr_i[3:0]];
  end
  // Undriven bus shows the inverse of the last word, not a stale copy
  assign rdata_o = (!rd_n_i && !float_i) ? mem[addr_i[3:0]] : ~last_q;
endmodule

`default_nettype wire

// ==== bench/dmp_top_asserts.sv ====
`default_nettype none
`include "dmp_params.svh"

module dmp_top_asserts import dmp_pkg::*; #(
  parameter int PBANKS = `DMP_PBANKS,
  parameter int DBANKS = `DMP_DBANKS
) (
  input wire logic              clk_sys_i,
  input wire logic              reset_i,
  input wire logic              prog_read_strobe_n_o,
  input wire logic              prog_write_strobe_n_o,
  input wire logic [PBANKS-1:0] prog_bank_select_n_o,
  input wire logic              prog_pins_oe_n_o,
  input wire logic              prog_mem_data_oe_n_o,
  input wire logic              prog_done_o,
  input wire logic              prog_acknowledge_i,
  input wire logic              prog_port_float_n_i,
  input wire logic              data_read_strobe_n_o,
  input wire logic              data_write_strobe_n_o,
  input wire logic [DBANKS-1:0] data_bank_select_n_o,
  input wire logic              data_pins_oe_n_o,
  input wire logic              data_mem_bus_oe_n_o,
  input wire logic              data_done_o,
  input wire logic              data_acknowledge_i,
  input wire logic              data_port_float_n_i
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);

  // ========================================================================
  // Strobes, selects, float and completion
  AST_P_RW: assert property (prog_read_strobe_n_o || prog_write_strobe_n_o)
    else $error("prog strobes both low");
  AST_D_RW: assert property (data_read_strobe_n_o || data_write_strobe_n_o)
    else $error("data strobes both low");
  AST_P_SEL: assert property (!(prog_read_strobe_n_o && prog_write_strobe_n_o)
    |-> $onehot(~prog_bank_select_n_o)) else $error("prog select not one-hot");
  AST_D_SEL: assert property (!(data_read_strobe_n_o && data_write_strobe_n_o)
    |-> $onehot(~data_bank_select_n_o)) else $error("data select not one-hot");
  AST_P_FLT: assert property (!prog_port_float_n_i
    |=> prog_pins_oe_n_o && prog_mem_data_oe_n_o) else $error("prog port not floated");
  AST_D_FLT: assert property (!data_port_float_n_i
    |=> data_pins_oe_n_o && data_mem_bus_oe_n_o) else $error("data port not floated");
  // Ack seen in the floated cycle must not finish the access
  AST_P_HALT: assert property (!prog_port_float_n_i ##1 !prog_port_float_n_i
    |=> !prog_done_o) else $error("prog access done while floated");
  AST_D_HALT: assert property (!data_port_float_n_i ##1 !data_port_float_n_i
    |=> !data_done_o) else $error("data access done while floated");
  AST_P_DONE: assert property (prog_done_o |-> $past(prog_acknowledge_i) &&
    !($past(prog_read_strobe_n_o) && $past(prog_write_strobe_n_o)))
    else $error("prog done without ack");
  AST_D_DONE: assert property (data_done_o |-> $past(data_acknowledge_i) &&
    !($past(data_read_strobe_n_o) && $past(data_write_strobe_n_o)))
    else $error("data done without ack");
endmodule

bind dmp_top dmp_top_asserts #(.PBANKS(PBANKS), .DBANKS(DBANKS)) u_dmp_top_asserts (.*);

`default_nettype wire

// ==== bench/dmp_top_test.sv ====
`default_nettype none
`include "dmp_params.svh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin error_cnt++; \
  $display("ERROR t=%0t got %0h exp %0h", $time, (g), (e)); end end

module dmp_top_test import dmp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [47:0] DV = 48'hA5A5_0F0F_1234;
  localparam logic [31:0] WV = 32'hC3C3_5A5A;
  logic clk_sys_i = 0, reset_i = 1, prog_req_valid_i = 0, data_req_valid_i = 0;
  logic prog_req_ready_o, prog_done_o, prog_mem_data_oe_n_o, prog_read_strobe_n_o;
  logic prog_write_strobe_n_o, prog_pins_oe_n_o, prog_page_cross_o, prog_acknowledge_i;
  logic data_req_ready_o, data_done_o, data_mem_bus_oe_n_o, data_read_strobe_n_o;
  logic data_write_strobe_n_o, data_pins_oe_n_o, data_page_cross_o, data_acknowledge_i;
  logic prog_port_float_n_i = 1, data_port_float_n_i = 1, pg;
  dmp_prog_req_t prog_req_i = '0;
  dmp_data_req_t data_req_i = '0;
  logic [47:0] prog_rdata_o, prog_mem_data_o, prog_mem_data_i, q;
  logic [39:0] data_rdata_o, data_mem_bus_o, data_mem_bus_i;
  logic [23:0] prog_mem_addr_o, prog_bank_bound_i = 24'h000100;
  logic [31:0] data_mem_addr_o, av;
  logic [95:0] data_bank_bound_i = {32'h300, 32'h200, 32'h100};
  logic [5:0]  prog_bank_wait_i = {3'h3, 3'h0};
  logic [11:0] data_bank_wait_i = {3'h7, 3'h2, 3'h1, 3'h0};
  logic [4:0]  prog_page_bits_i = 5'h04, data_page_bits_i = 5'h04;
  logic [1:0]  prog_bank_select_n_o, st, sw;
  logic [3:0]  data_bank_select_n_o, s;
  logic [7:0]  pst = 8'h00, dst = 8'h00;
  int          error_cnt = 0, n_compared = 0, cyc = 0, lat;

  dmp_top u_dmp_top (.*);
  dmp_mem_model #(.AW(24), .DW(48)) u_dmp_mem_model_prog (.clk_i(clk_sys_i),
    .addr_i(prog_mem_addr_o), .wdata_i(prog_mem_data_o), .rd_n_i(prog_read_strobe_n_o),
    .wr_n_i(prog_write_strobe_n_o), .float_i(prog_pins_oe_n_o), .stall_i(pst),
    .ack_o(prog_acknowledge_i), .rdata_o(prog_mem_data_i));
  dmp_mem_model #(.AW(32), .DW(40)) u_dmp_mem_model_data (.clk_i(clk_sys_i),
    .addr_i(data_mem_addr_o), .wdata_i(data_mem_bus_o), .rd_n_i(data_read_strobe_n_o),
    .wr_n_i(data_write_strobe_n_o), .float_i(data_pins_oe_n_o), .stall_i(dst),
    .ack_o(data_acknowledge_i), .rdata_o(data_mem_bus_i));

  // ========================================================================
  // Clock, hang guard and verdict
  always #2 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      close_out();
    end
  end
  task automatic close_out;
    $display("Compared %0d, errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  function automatic logic [47:0] dd(input bit p);
    return p ? {8'h00, DV[39:0]} : DV;
  endfunction

  // One access; pins captured in the first strobe cycle, latency in cycles
  task automatic acc(input bit p, w, w32, input logic [31:0] a, input logic [47:0] d);
    @(negedge clk_sys_i);
    if (p) {data_req_i, data_req_valid_i} = {w, w32, a, d[39:0], 1'b1};
    else {prog_req_i, prog_req_valid_i} = {w, w32, a[23:0], d, 1'b1};
    // Ready judged while settled, so the take edge is never raced
    while ((p ? data_req_ready_o : prog_req_ready_o) !== 1'b1) @(negedge clk_sys_i);
    @(posedge clk_sys_i);
    lat = 0;
    do begin
      @(negedge clk_sys_i);
      {prog_req_valid_i, data_req_valid_i} = 2'b00;
      lat++;
      st = p ? {data_read_strobe_n_o, data_write_strobe_n_o}
             : {prog_read_strobe_n_o, prog_write_strobe_n_o};
      if (lat == 1) begin
        sw = st;
        s  = p ? data_bank_select_n_o : {2'b11, prog_bank_select_n_o};
        pg = p ? data_page_cross_o : prog_page_cross_o;
        av = p ? data_mem_addr_o : {8'h00, prog_mem_addr_o};
      end
    end while ((p ? data_done_o : prog_done_o) !== 1'b1 && lat < 99);
    q = p ? {8'h00, data_rdata_o} : prog_rdata_o;
  endtask

  // ========================================================================
  // Scenarios
  task automatic t_rw(input bit p);
    acc(p, 1, 0, 32'h11, DV);
    `CHK(sw, 2'b10)
    acc(p, 0, 0, 32'h11, '0);
    `CHK(sw, 2'b01)
    `CHK(q, dd(p))
    acc(p, 1, 1, 32'h12, {16'h0000, WV});
    acc(p, 0, 0, 32'h12, '0);
    `CHK(q, p ? {8'h00, WV, 8'h00} : {WV, 16'h0000})
    acc(p, 0, 1, 32'h12, '0);
    `CHK(q, {16'h0000, WV})
  endtask
  task automatic t_bank(input bit p);
    for (int b = 0; b < (p ? 4 : 2); b++) begin
      acc(p, 1, 0, 32'h50 + b * 32'h100, '0);
      `CHK(s, ~(4'h1 << b) | (p ? 4'h0 : 4'hC))
      `CHK(av, 32'h50 + b * 32'h100)
      `CHK(lat, 2 + (p ? data_bank_wait_i[3*b+:3] : prog_bank_wait_i[3*b+:3]))
    end
  endtask
  task automatic t_ack(input bit p);
    if (p) dst = 8'h03;
    else pst = 8'h03;
    acc(p, 0, 0, 32'h11, '0);
    `CHK(lat, 5)
    `CHK(q, dd(p))
    {pst, dst} = 16'h0000;
  endtask
  task automatic t_page(input bit p);
    logic [31:0] pa [3] = '{32'h17, 32'h18, 32'h20};
    logic [31:0] prv = 32'h10;
    int n;
    n = p ? 4 : 3;
    prog_page_bits_i = 5'h03;
    acc(p, 1, 0, prv, '0);
    foreach (pa[i]) begin
      acc(p, 1, 0, pa[i], '0);
      `CHK(pg, (pa[i] >> n) != (prv >> n))
      prv = pa[i];
    end
  endtask
  task automatic t_float(input bit p);
    if (p) dst = 8'h06;
    else pst = 8'h06;
    fork
      acc(p, 0, 0, 32'h11, '0);
      begin
        repeat (3) @(negedge clk_sys_i);
        {prog_port_float_n_i, data_port_float_n_i} = p ? 2'b10 : 2'b01;
        repeat (2) @(negedge clk_sys_i);
        `CHK(p ? data_pins_oe_n_o : prog_pins_oe_n_o, 1'b1)
        repeat (8) @(negedge clk_sys_i);
        {prog_port_float_n_i, data_port_float_n_i} = 2'b11;
      end
    join
    `CHK(lat >= 13, 1'b1)
    `CHK(q, dd(p))
    {pst, dst} = 16'h0000;
  endtask

  initial begin
    repeat (5) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    reset_i = 0;
    for (int p = 0; p < 2; p++) begin
      t_rw(p[0]);
      t_bank(p[0]);
      t_ack(p[0]);
      t_page(p[0]);
      t_float(p[0]);
    end
    close_out();
  end
endmodule

`default_nettype wire

// ==== rtl/dmp_bank_page.sv ====
`default_nettype none
`include "dmp_params.svh"

module dmp_bank_page import dmp_pkg::*; #(
  parameter int AW  = `DMP_DA_W,
  parameter int NB  = `DMP_DBANKS,
  parameter int WSW = `DMP_WS_W,
  parameter int PBW = `DMP_PGB_W
) (
  input  wire logic [AW-1:0]          addr_i,
  input  wire logic [AW-1:0]          last_addr_i,
  input  wire logic [(NB-1)*AW-1:0]   bounds_i,
  input  wire logic [NB*WSW-1:0]      waits_i,
  input  wire logic [PBW-1:0]         page_bits_i,
  output logic      [NB-1:0]          sel_n_o,
  output logic      [WSW-1:0]         wait_o,
  output logic                        cross_o
);

  logic [NB:0] above;

  // ========================================================================
  // Bank decode: bounds ascend, bank b starts at bound b-1
  assign above[0]  = 1'b1;
  assign above[NB] = 1'b0;
  for (genvar b = 0; b < NB; b++) begin : g_bank
    if (b > 0) begin : g_cmp
      assign above[b] = (addr_i >= bounds_i[(b-1)*AW +: AW]);
    end
    assign sel_n_o[b] = ~(above[b] & ~above[b+1]);
  end

  // Wait states of the selected bank
  always_comb begin
    wait_o = '0;
    for (int b = 0; b < NB; b++) begin
      if (!sel_n_o[b]) begin
        wait_o = wait_o | waits_i[b*WSW +: WSW];
      end
    end
  end

  // Page number differs from the previous access
  assign cross_o = ((addr_i >> page_bits_i) != (last_addr_i >> page_bits_i));

endmodule

`default_nettype wire

// ==== rtl/dmp_params.svh ====
`ifndef DMP_PARAMS_SVH
`define DMP_PARAMS_SVH

// ==========================================================================
// Pin group widths
`define DMP_PA_W      24
`define DMP_PD_W      48
`define DMP_DA_W      32
`define DMP_DD_W      40
`define DMP_W32       32
`define DMP_PD_LSB32  (`DMP_PD_W - `DMP_W32)
`define DMP_DD_LSB32  (`DMP_DD_W - `DMP_W32)

// ==========================================================================
// Bank setup
`define DMP_PBANKS    2
`define DMP_DBANKS    4
`define DMP_WS_W      3
`define DMP_PGB_W     5

`endif

// ==== rtl/dmp_pkg.sv ====
`default_nettype none
`include "dmp_params.svh"

package dmp_pkg;

  // ========================================================================
  // Access requests from the core, one per port
  typedef struct packed {
    logic                 write;   // 1 = write, 0 = read
    logic                 word32;  // 32-bit value, justified to the top bits
    logic [`DMP_PA_W-1:0] addr;
    logic [`DMP_PD_W-1:0] wdata;
  } dmp_prog_req_t;

  typedef struct packed {
    logic                 write;
    logic                 word32;
    logic [`DMP_DA_W-1:0] addr;
    logic [`DMP_DD_W-1:0] wdata;
  } dmp_data_req_t;

  // ========================================================================
  // Port sequencer states
  typedef enum logic [2:0] {
    DMP_ST_IDLE = 3'h1,
    DMP_ST_ACC  = 3'h2,
    DMP_ST_HOLD = 3'h4
  } dmp_state_t;

endpackage

`default_nettype wire

// ==== rtl/dmp_top.sv ====
// Function
// - Drive 24-bit program address for every program memory access.
// - Move 48-bit program data; 32-bit values use bits 47 to 16.
// - Assert one of two program bank selects decoded from address.
// - Program read strobe on reads, write strobe on writes.
// - Program acknowledge low stretches the program access.
// - Program page output when a program access crosses a page.
// - Program float control puts all program outputs in high impedance.
// - Program float during an access halts it uncompleted until released.
// - Drive 32-bit data address for every data memory access.
// - Move 40-bit data; 32-bit values use bits 39 to 8.
// - Assert one of four data bank selects decoded from address.
// - Data read strobe on reads, write strobe on writes.
// - Data acknowledge low stretches the data access.
// - Synchronous inputs sampled on the input clock.
// - Highest numbered pin of each group is the MSB.
// - Data page output when a data access crosses a page.
// - Data float hides data outputs and halts a pending access.
// - Each bank has zero to seven internal wait states plus acknowledge.
`default_nettype none
`include "dmp_params.svh"

module dmp_top import dmp_pkg::*; #(
  parameter int PBANKS = `DMP_PBANKS,
  parameter int DBANKS = `DMP_DBANKS
) (
  input  wire logic                          clk_sys_i,
  input  wire logic                          reset_i,
  // Program side, core facing
  input  wire logic                          prog_req_valid_i,
  input  wire dmp_prog_req_t                 prog_req_i,
  output logic                               prog_req_ready_o,
  output logic                               prog_done_o,
  output logic      [`DMP_PD_W-1:0]          prog_rdata_o,
  input  wire logic [(PBANKS-1)*`DMP_PA_W-1:0] prog_bank_bound_i,
  input  wire logic [PBANKS*`DMP_WS_W-1:0]   prog_bank_wait_i,
  input  wire logic [`DMP_PGB_W-1:0]         prog_page_bits_i,
  // Program side, pins
  output logic      [`DMP_PA_W-1:0]          prog_mem_addr_o,
  output logic      [`DMP_PD_W-1:0]          prog_mem_data_o,
  input  wire logic [`DMP_PD_W-1:0]          prog_mem_data_i,
  output logic                               prog_mem_data_oe_n_o,
  output logic      [PBANKS-1:0]             prog_bank_select_n_o,
  output logic                               prog_read_strobe_n_o,
  output logic                               prog_write_strobe_n_o,
  output logic                               prog_pins_oe_n_o,
  output logic                               prog_page_cross_o,
  input  wire logic                          prog_acknowledge_i,
  input  wire logic                          prog_port_float_n_i,
  // Data side, core facing
  input  wire logic                          data_req_valid_i,
  input  wire dmp_data_req_t                 data_req_i,
  output logic                               data_req_ready_o,
  output logic                               data_done_o,
  output logic      [`DMP_DD_W-1:0]          data_rdata_o,
  input  wire logic [(DBANKS-1)*`DMP_DA_W-1:0] data_bank_bound_i,
  input  wire logic [DBANKS*`DMP_WS_W-1:0]   data_bank_wait_i,
  input  wire logic [`DMP_PGB_W-1:0]         data_page_bits_i,
  // Data side, pins
  output logic      [`DMP_DA_W-1:0]          data_mem_addr_o,
  output logic      [`DMP_DD_W-1:0]          data_mem_bus_o,
  input  wire logic [`DMP_DD_W-1:0]          data_mem_bus_i,
  output logic                               data_mem_bus_oe_n_o,
  output logic      [DBANKS-1:0]             data_bank_select_n_o,
  output logic                               data_read_strobe_n_o,
  output logic                               data_write_strobe_n_o,
  output logic                               data_pins_oe_n_o,
  output logic                               data_page_cross_o,
  input  wire logic                          data_acknowledge_i,
  input  wire logic                          data_port_float_n_i
);

  // ========================================================================
  // Program port state
  dmp_state_t               p_state_ff,  nxt_p_state;
  logic [`DMP_PA_W-1:0]     p_addr_ff,   nxt_p_addr;
  logic [`DMP_PA_W-1:0]     p_last_ff,   nxt_p_last;
  logic [`DMP_PD_W-1:0]     p_wdata_ff,  nxt_p_wdata;
  logic [`DMP_PD_W-1:0]     p_rdata_ff,  nxt_p_rdata;
  logic [`DMP_WS_W-1:0]     p_wait_ff,   nxt_p_wait;
  logic [PBANKS-1:0]        p_sel_n_ff,  nxt_p_sel_n;
  logic                     p_write_ff,  nxt_p_write;
  logic                     p_w32_ff,    nxt_p_w32;
  logic                     p_page_ff,   nxt_p_page;
  logic                     p_done_ff,   nxt_p_done;
  logic                     p_ready_ff,  nxt_p_ready;
  logic                     p_rd_n_ff,   nxt_p_rd_n;
  logic                     p_wr_n_ff,   nxt_p_wr_n;
  logic                     p_doe_n_ff,  nxt_p_doe_n;
  logic                     p_poe_n_ff,  nxt_p_poe_n;
  logic [PBANKS-1:0]        p_dec_sel_n;
  logic [`DMP_WS_W-1:0]     p_dec_wait;
  logic                     p_dec_cross;
  logic                     p_float;

  // ========================================================================
  // Data port state
  dmp_state_t               d_state_ff,  nxt_d_state;
  logic [`DMP_DA_W-1:0]     d_addr_ff,   nxt_d_addr;
  logic [`DMP_DA_W-1:0]     d_last_ff,   nxt_d_last;
  logic [`DMP_DD_W-1:0]     d_wdata_ff,  nxt_d_wdata;
  logic [`DMP_DD_W-1:0]     d_rdata_ff,  nxt_d_rdata;
  logic [`DMP_WS_W-1:0]     d_wait_ff,   nxt_d_wait;
  logic [DBANKS-1:0]        d_sel_n_ff,  nxt_d_sel_n;
  logic                     d_write_ff,  nxt_d_write;
  logic                     d_w32_ff,    nxt_d_w32;
  logic                     d_page_ff,   nxt_d_page;
  logic                     d_done_ff,   nxt_d_done;
  logic                     d_ready_ff,  nxt_d_ready;
  logic                     d_rd_n_ff,   nxt_d_rd_n;
  logic                     d_wr_n_ff,   nxt_d_wr_n;
  logic                     d_doe_n_ff,  nxt_d_doe_n;
  logic                     d_poe_n_ff,  nxt_d_poe_n;
  logic [DBANKS-1:0]        d_dec_sel_n;
  logic [`DMP_WS_W-1:0]     d_dec_wait;
  logic                     d_dec_cross;
  logic                     d_float;

  // Float controls and acknowledges are synchronous pins, used directly
  assign p_float = ~prog_port_float_n_i;
  assign d_float = ~data_port_float_n_i;

  // ========================================================================
  // Bank and page decode of the incoming request addresses
  dmp_bank_page #(
    .AW  (`DMP_PA_W),
    .NB  (PBANKS),
    .WSW (`DMP_WS_W),
    .PBW (`DMP_PGB_W)
  ) u_prog_dec (
    .addr_i      (prog_req_i.addr),
    .last_addr_i (p_last_ff),
    .bounds_i    (prog_bank_bound_i),
    .waits_i     (prog_bank_wait_i),
    .page_bits_i (prog_page_bits_i),
    .sel_n_o     (p_dec_sel_n),
    .wait_o      (p_dec_wait),
    .cross_o     (p_dec_cross)
  );

  dmp_bank_page #(
    .AW  (`DMP_DA_W),
    .NB  (DBANKS),
    .WSW (`DMP_WS_W),
    .PBW (`DMP_PGB_W)
  ) u_data_dec (
    .addr_i      (data_req_i.addr),
    .last_addr_i (d_last_ff),
    .bounds_i    (data_bank_bound_i),
    .waits_i     (data_bank_wait_i),
    .page_bits_i (data_page_bits_i),
    .sel_n_o     (d_dec_sel_n),
    .wait_o      (d_dec_wait),
    .cross_o     (d_dec_cross)
  );

  // ========================================================================
  // Program port sequencer: idle, strobing, or halted under float
  always_comb begin
    nxt_p_state = p_state_ff;
    nxt_p_addr  = p_addr_ff;
    nxt_p_last  = p_last_ff;
    nxt_p_wdata = p_wdata_ff;
    nxt_p_rdata = p_rdata_ff;
    nxt_p_wait  = p_wait_ff;
    nxt_p_sel_n = p_sel_n_ff;
    nxt_p_write = p_write_ff;
    nxt_p_w32   = p_w32_ff;
    nxt_p_page  = p_page_ff;
    nxt_p_rd_n  = p_rd_n_ff;
    nxt_p_wr_n  = p_wr_n_ff;
    nxt_p_done  = 1'b0;
    case (p_state_ff)
      DMP_ST_IDLE: begin
        if (prog_req_valid_i && p_ready_ff) begin
          nxt_p_addr  = prog_req_i.addr;
          nxt_p_last  = prog_req_i.addr;
          nxt_p_write = prog_req_i.write;
          nxt_p_w32   = prog_req_i.word32;
          nxt_p_wdata = prog_req_i.word32 ?
                        {prog_req_i.wdata[`DMP_W32-1:0], {`DMP_PD_LSB32{1'b0}}} :
                        prog_req_i.wdata;
          nxt_p_sel_n = p_dec_sel_n;
          nxt_p_wait  = p_dec_wait;
          nxt_p_page  = p_dec_cross;
          nxt_p_rd_n  = prog_req_i.write;
          nxt_p_wr_n  = ~prog_req_i.write;
          nxt_p_state = p_float ? DMP_ST_HOLD : DMP_ST_ACC;
        end
      end
      DMP_ST_ACC: begin
        if (p_float) begin
          nxt_p_state = DMP_ST_HOLD;
        end else if (p_wait_ff != '0) begin
          nxt_p_wait = p_wait_ff - 1'b1;
        end else if (prog_acknowledge_i) begin
          nxt_p_done  = 1'b1;
          nxt_p_rdata = p_w32_ff ?
                        {{`DMP_PD_LSB32{1'b0}}, prog_mem_data_i[`DMP_PD_W-1:`DMP_PD_LSB32]} :
                        prog_mem_data_i;
          nxt_p_sel_n = '1;
          nxt_p_rd_n  = 1'b1;
          nxt_p_wr_n  = 1'b1;
          nxt_p_page  = 1'b0;
          nxt_p_state = DMP_ST_IDLE;
        end
      end
      DMP_ST_HOLD: begin
        // Resume and wait for the acknowledge the far side gives on release
        if (!p_float) begin
          nxt_p_state = DMP_ST_ACC;
        end
      end
      default: begin
        nxt_p_state = DMP_ST_IDLE;
      end
    endcase
    nxt_p_poe_n = p_float;
    nxt_p_doe_n = p_float | ~nxt_p_write | (nxt_p_state == DMP_ST_IDLE);
    nxt_p_ready = (nxt_p_state == DMP_ST_IDLE) & ~p_float;
  end

  // Program port registers
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      p_state_ff <= DMP_ST_IDLE;
      p_addr_ff  <= '0;
      p_last_ff  <= '0;
      p_wdata_ff <= '0;
      p_rdata_ff <= '0;
      p_wait_ff  <= '0;
      p_sel_n_ff <= '1;
      p_write_ff <= 1'b0;
      p_w32_ff   <= 1'b0;
      p_page_ff  <= 1'b0;
      p_done_ff  <= 1'b0;
      p_ready_ff <= 1'b0;
      p_rd_n_ff  <= 1'b1;
      p_wr_n_ff  <= 1'b1;
      p_doe_n_ff <= 1'b1;
      p_poe_n_ff <= 1'b1;
    end else begin
      p_state_ff <= nxt_p_state;
      p_addr_ff  <= nxt_p_addr;
      p_last_ff  <= nxt_p_last;
      p_wdata_ff <= nxt_p_wdata;
      p_rdata_ff <= nxt_p_rdata;
      p_wait_ff  <= nxt_p_wait;
      p_sel_n_ff <= nxt_p_sel_n;
      p_write_ff <= nxt_p_write;
      p_w32_ff   <= nxt_p_w32;
      p_page_ff  <= nxt_p_page;
      p_done_ff  <= nxt_p_done;
      p_ready_ff <= nxt_p_ready;
      p_rd_n_ff  <= nxt_p_rd_n;
      p_wr_n_ff  <= nxt_p_wr_n;
      p_doe_n_ff <= nxt_p_doe_n;
      p_poe_n_ff <= nxt_p_poe_n;
    end
  end

  // ========================================================================
  // Data port sequencer, same scheme as the program port
  always_comb begin
    nxt_d_state = d_state_ff;
    nxt_d_addr  = d_addr_ff;
    nxt_d_last  = d_last_ff;
    nxt_d_wdata = d_wdata_ff;
    nxt_d_rdata = d_rdata_ff;
    nxt_d_wait  = d_wait_ff;
    nxt_d_sel_n = d_sel_n_ff;
    nxt_d_write = d_write_ff;
    nxt_d_w32   = d_w32_ff;
    nxt_d_page  = d_page_ff;
    nxt_d_rd_n  = d_rd_n_ff;
    nxt_d_wr_n  = d_wr_n_ff;
    nxt_d_done  = 1'b0;
    case (d_state_ff)
      DMP_ST_IDLE: begin
        if (data_req_valid_i && d_ready_ff) begin
          nxt_d_addr  = data_req_i.addr;
          nxt_d_last  = data_req_i.addr;
          nxt_d_write = data_req_i.write;
          nxt_d_w32   = data_req_i.word32;
          nxt_d_wdata = data_req_i.word32 ?
                        {data_req_i.wdata[`DMP_W32-1:0], {`DMP_DD_LSB32{1'b0}}} :
                        data_req_i.wdata;
          nxt_d_sel_n = d_dec_sel_n;
          nxt_d_wait  = d_dec_wait;
          nxt_d_page  = d_dec_cross;
          nxt_d_rd_n  = data_req_i.write;
          nxt_d_wr_n  = ~data_req_i.write;
          nxt_d_state = d_float ? DMP_ST_HOLD : DMP_ST_ACC;
        end
      end
      DMP_ST_ACC: begin
        if (d_float) begin
          nxt_d_state = DMP_ST_HOLD;
        end else if (d_wait_ff != '0) begin
          nxt_d_wait = d_wait_ff - 1'b1;
        end else if (data_acknowledge_i) begin
          nxt_d_done  = 1'b1;
          nxt_d_rdata = d_w32_ff ?
                        {{`DMP_DD_LSB32{1'b0}}, data_mem_bus_i[`DMP_DD_W-1:`DMP_DD_LSB32]} :
                        data_mem_bus_i;
          nxt_d_sel_n = '1;
          nxt_d_rd_n  = 1'b1;
          nxt_d_wr_n  = 1'b1;
          nxt_d_page  = 1'b0;
          nxt_d_state = DMP_ST_IDLE;
        end
      end
      DMP_ST_HOLD: begin
        if (!d_float) begin
          nxt_d_state = DMP_ST_ACC;
        end
      end
      default: begin
        nxt_d_state = DMP_ST_IDLE;
      end
    endcase
    nxt_d_poe_n = d_float;
    nxt_d_doe_n = d_float | ~nxt_d_write | (nxt_d_state == DMP_ST_IDLE);
    nxt_d_ready = (nxt_d_state == DMP_ST_IDLE) & ~d_float;
  end

  // Data port registers
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      d_state_ff <= DMP_ST_IDLE;
      d_addr_ff  <= '0;
      d_last_ff  <= '0;
      d_wdata_ff <= '0;
      d_rdata_ff <= '0;
      d_wait_ff  <= '0;
      d_sel_n_ff <= '1;
      d_write_ff <= 1'b0;
      d_w32_ff   <= 1'b0;
      d_page_ff  <= 1'b0;
      d_done_ff  <= 1'b0;
      d_ready_ff <= 1'b0;
      d_rd_n_ff  <= 1'b1;
      d_wr_n_ff  <= 1'b1;
      d_doe_n_ff <= 1'b1;
      d_poe_n_ff <= 1'b1;
    end else begin
      d_state_ff <= nxt_d_state;
      d_addr_ff  <= nxt_d_addr;
      d_last_ff  <= nxt_d_last;
      d_wdata_ff <= nxt_d_wdata;
      d_rdata_ff <= nxt_d_rdata;
      d_wait_ff  <= nxt_d_wait;
      d_sel_n_ff <= nxt_d_sel_n;
      d_write_ff <= nxt_d_write;
      d_w32_ff   <= nxt_d_w32;
      d_page_ff  <= nxt_d_page;
      d_done_ff  <= nxt_d_done;
      d_ready_ff <= nxt_d_ready;
      d_rd_n_ff  <= nxt_d_rd_n;
      d_wr_n_ff  <= nxt_d_wr_n;
      d_doe_n_ff <= nxt_d_doe_n;
      d_poe_n_ff <= nxt_d_poe_n;
    end
  end

  // ========================================================================
  // Outputs, all straight from flops; float takes effect one edge later
  assign prog_req_ready_o      = p_ready_ff;
  assign prog_done_o           = p_done_ff;
  assign prog_rdata_o          = p_rdata_ff;
  assign prog_mem_addr_o       = p_addr_ff;
  assign prog_mem_data_o       = p_wdata_ff;
  assign prog_mem_data_oe_n_o  = p_doe_n_ff;
  assign prog_bank_select_n_o  = p_sel_n_ff;
  assign prog_read_strobe_n_o  = p_rd_n_ff;
  assign prog_write_strobe_n_o = p_wr_n_ff;
  assign prog_pins_oe_n_o      = p_poe_n_ff;
  assign prog_page_cross_o     = p_page_ff;
  assign data_req_ready_o      = d_ready_ff;
  assign data_done_o           = d_done_ff;
  assign data_rdata_o          = d_rdata_ff;
  assign data_mem_addr_o       = d_addr_ff;
  assign data_mem_bus_o        = d_wdata_ff;
  assign data_mem_bus_oe_n_o   = d_doe_n_ff;
  assign data_bank_select_n_o  = d_sel_n_ff;
  assign data_read_strobe_n_o  = d_rd_n_ff;
  assign data_write_strobe_n_o = d_wr_n_ff;
  assign data_pins_oe_n_o      = d_poe_n_ff;
  assign data_page_cross_o     = d_page_ff;

endmodule

`default_nettype wire
